// ### src/dba_pkg.sv
// Package: constants and types for the boot mode and axis id loader
`default_nettype none
package dba_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int HALL_HOLD_MS = 1000;
  localparam int HALL_HOLD_CYC = (CLK_HZ / 1000) * HALL_HOLD_MS;
  localparam logic [3:0] SETTLE_CYC = 4'h8;
  // ==========================================================
  // Nonvolatile memory flag word
  localparam logic [15:0] NVM_AUTORUN_ADDR = 16'h4000;
  localparam logic [15:0] NVM_AUTORUN_OFF = 16'h0001;
  // ==========================================================
  // Identifiers
  localparam logic [7:0] ID_UNCONF = 8'hFF;
  localparam logic [7:0] ID_CANOPEN_MAX = 8'h7F;
  localparam logic [7:0] ID_NONE = 8'h00;
  localparam logic [3:0] ROT_ZERO = 4'h0;
  localparam logic [2:0] HALL_ALL_LOW = 3'h0;
  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_AXIS = 8'h04;
  localparam logic [7:0] REG_AUTORUN = 8'h08;
  localparam logic [7:0] REG_LSS = 8'h0C;
  // Status fields
  localparam int ST_CANOPEN = 0;
  localparam int ST_AUTORUN = 1;
  localparam int ST_SLAVE = 2;
  localparam int ST_LSS_UNCONF = 3;
  localparam int ST_RUNNING = 4;
  localparam int ST_DONE = 5;
  localparam int ST_LED = 6;
  localparam int ST_NVM_BUSY = 7;
  localparam int ST_PROG_VALID = 8;
  // Control fields
  localparam int AR_DISABLE_BIT = 0;
  localparam int LSS_STORE_BIT = 8;
  // Axis register fields
  localparam int AX_SERIAL_LSB = 8;
  // ==========================================================
  // Power-on sequencer
  typedef enum logic [3:0] {
    S_SETTLE = 4'b0001,
    S_READ = 4'b0010,
    S_HALL = 4'b0100,
    S_DONE = 4'b1000
  } dba_state_t;

  // Identifier usable on the CAN network
  function automatic logic dba_id_ok(input logic [7:0] id);
    dba_id_ok = (id != ID_NONE) && (id <= ID_CANOPEN_MAX);
  endfunction
endpackage
`default_nettype wire

// ### src/dba_pin_sync.sv
// Module: three-stage pin synchroniser, accepts a bit once stages agree
`default_nettype none
module dba_pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  // ==========================================================
  // Chain; ff1 feeds only ff2
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // ==========================================================
  // Per bit: a change counts only when stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= (ff2 & ~(ff2 ^ ff3)) | (q & (ff2 ^ ff3));
    end
  end
endmodule
`default_nettype wire

// ### src/dba_boot_cfg.sv
// Module: power-on boot mode, autorun and axis id loader with APB access
//
// Implementation choices: the address map and the APB slave port.
`default_nettype none
module dba_boot_cfg
  import dba_pkg::*;
#(
  parameter int HALL_HOLD_CYCLES = HALL_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic protocol_switch,
  input wire logic [3:0] axis_id_rotary_switch,
  input wire logic [2:0] hall_in,
  input wire logic motor_supply_ok,
  input wire logic program_valid_in,
  output logic nvm_rd_req,
  output logic [15:0] nvm_addr,
  input wire logic nvm_rd_valid,
  input wire logic [15:0] nvm_rd_data,
  output logic nvm_wr_req,
  output logic [15:0] nvm_wr_data,
  input wire logic nvm_wr_ack,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic canopen_mode,
  output logic native_command_protocol_mode,
  output logic autorun_mode,
  output logic slave_mode,
  output logic program_run,
  output logic green_led,
  output logic cfg_done,
  output logic lss_unconf,
  output logic can_comm_en,
  output logic [7:0] axis_id,
  output logic [7:0] serial_axis_id
);
  dba_state_t state;
  logic [8:0] s_vec;
  logic s_proto;
  logic [3:0] s_rot;
  logic [2:0] s_hall;
  logic s_motor;
  logic hall_low;
  logic [3:0] settle_cnt;
  logic [31:0] hall_cnt;
  logic prog_valid;
  logic st_read;
  logic apb_wr;
  logic apb_setup;
  logic lss_take;

  // ==========================================================
  // Pin synchronisers
  dba_pin_sync #(.W(9)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .d({motor_supply_ok, hall_in, axis_id_rotary_switch, protocol_switch}),
    .q(s_vec)
  );
  assign s_proto = s_vec[0];
  assign s_rot = s_vec[4:1];
  assign s_hall = s_vec[7:5];
  assign s_motor = s_vec[8];
  assign hall_low = (s_hall == HALL_ALL_LOW);
  assign st_read = (state == S_READ);

  // ==========================================================
  // APB decode; writes land only on the completing edge
  assign apb_setup = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  assign lss_take = apb_wr && (paddr == REG_LSS)
    && pwdata[LSS_STORE_BIT] && lss_unconf
    && dba_id_ok(pwdata[7:0]);

  // ==========================================================
  // Power-on sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_SETTLE;
      settle_cnt <= 4'h0;
      hall_cnt <= 32'h0;
      canopen_mode <= 1'b0;
      native_command_protocol_mode <= 1'b0;
      autorun_mode <= 1'b0;
      slave_mode <= 1'b0;
      green_led <= 1'b0;
      prog_valid <= 1'b0;
      cfg_done <= 1'b0;
    end else begin
      case (state)
        S_SETTLE: begin
          // Wait out the synchroniser before trusting pins
          settle_cnt <= settle_cnt + 4'h1;
          if (settle_cnt == SETTLE_CYC - 4'h1) begin
            canopen_mode <= s_proto;
            native_command_protocol_mode <= !s_proto;
            state <= S_READ;
          end
        end
        S_READ: begin
          if (nvm_rd_valid) begin
            prog_valid <= program_valid_in;
            if (canopen_mode || !program_valid_in
                || nvm_rd_data == NVM_AUTORUN_OFF) begin
              slave_mode <= 1'b1;
              cfg_done <= 1'b1;
              state <= S_DONE;
            end else if (hall_low) begin
              state <= S_HALL;
            end else begin
              autorun_mode <= 1'b1;
              cfg_done <= 1'b1;
              state <= S_DONE;
            end
          end
        end
        S_HALL: begin
          // Releasing the halls early falls back to autorun
          if (!hall_low) begin
            autorun_mode <= 1'b1;
            cfg_done <= 1'b1;
            state <= S_DONE;
          end else if (hall_cnt == 32'(HALL_HOLD_CYCLES - 1)) begin
            slave_mode <= 1'b1;
            green_led <= 1'b1;
            cfg_done <= 1'b1;
            state <= S_DONE;
          end else begin
            hall_cnt <= hall_cnt + 32'h1;
          end
        end
        S_DONE: begin
          state <= S_DONE;
        end
        default: begin
          state <= S_SETTLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Program start once motor supply appears; latched, no stop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      program_run <= 1'b0;
    end else if (cfg_done && autorun_mode && prog_valid && s_motor) begin
      program_run <= 1'b1;
    end
  end

  // ==========================================================
  // Axis identifier: rotary capture, then LSS assignment
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      axis_id <= ID_NONE;
      serial_axis_id <= ID_UNCONF;
      lss_unconf <= 1'b0;
    end else if (state == S_SETTLE && settle_cnt == SETTLE_CYC - 4'h1) begin
      if (s_rot == ROT_ZERO) begin
        axis_id <= s_proto ? ID_NONE : ID_UNCONF;
        serial_axis_id <= ID_UNCONF;
        lss_unconf <= s_proto;
      end else begin
        axis_id <= {4'h0, s_rot};
        serial_axis_id <= {4'h0, s_rot};
      end
    end else if (lss_take && cfg_done) begin
      // Out-of-range ids are dropped, never clamped
      axis_id <= pwdata[7:0];
      serial_axis_id <= pwdata[7:0];
      lss_unconf <= 1'b0;
    end
  end

  // ==========================================================
  // CAN traffic gate
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      can_comm_en <= 1'b0;
    end else begin
      can_comm_en <= cfg_done && !lss_unconf && !lss_take;
    end
  end

  // ==========================================================
  // Nonvolatile memory access
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nvm_rd_req <= 1'b0;
      nvm_addr <= NVM_AUTORUN_ADDR;
    end else begin
      nvm_rd_req <= st_read && !nvm_rd_valid && !nvm_rd_req;
      nvm_addr <= NVM_AUTORUN_ADDR;
    end
  end

  // Held until acknowledged; a later write while busy is absorbed
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nvm_wr_req <= 1'b0;
      nvm_wr_data <= 16'h0000;
    end else if (apb_wr && paddr == REG_AUTORUN
                 && pwdata[AR_DISABLE_BIT]) begin
      nvm_wr_req <= 1'b1;
      nvm_wr_data <= NVM_AUTORUN_OFF;
    end else if (nvm_wr_ack) begin
      nvm_wr_req <= 1'b0;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr)
          REG_STATUS: begin
            prdata[ST_CANOPEN] <= canopen_mode;
            prdata[ST_AUTORUN] <= autorun_mode;
            prdata[ST_SLAVE] <= slave_mode;
            prdata[ST_LSS_UNCONF] <= lss_unconf;
            prdata[ST_RUNNING] <= program_run;
            prdata[ST_DONE] <= cfg_done;
            prdata[ST_LED] <= green_led;
            prdata[ST_NVM_BUSY] <= nvm_wr_req;
            prdata[ST_PROG_VALID] <= prog_valid;
          end
          REG_AXIS: begin
            prdata[7:0] <= axis_id;
            prdata[AX_SERIAL_LSB +: 8] <= serial_axis_id;
          end
          REG_AUTORUN: begin
            prdata[AR_DISABLE_BIT] <= nvm_wr_req;
          end
          REG_LSS: begin
            prdata[7:0] <= axis_id;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_capture;
    $rose(st_read);
  endsequence

  sequence s_hall_expire;
    state == S_HALL && hall_low && hall_cnt == 32'(HALL_HOLD_CYCLES - 1);
  endsequence

  sequence s_autorun_write;
    apb_wr && paddr == REG_AUTORUN && pwdata[AR_DISABLE_BIT];
  endsequence

  a_proto_select: assert property (
    s_capture |-> canopen_mode == $past(s_proto)
      && native_command_protocol_mode == !$past(s_proto))
    else $error("protocol mode not taken from switch");

  a_autorun_entry: assert property (
    st_read && nvm_rd_valid && !canopen_mode && program_valid_in
      && nvm_rd_data != NVM_AUTORUN_OFF && !hall_low
      |=> autorun_mode && !slave_mode && cfg_done)
    else $error("autorun not entered");

  a_program_start: assert property (
    cfg_done && autorun_mode && prog_valid && s_motor |=> program_run)
    else $error("program did not start with motor supply");

  a_nvm_disable: assert property (
    s_autorun_write |=> nvm_wr_req && nvm_wr_data == NVM_AUTORUN_OFF)
    else $error("disable word not written");

  a_hall_slave: assert property (
    s_hall_expire |=> slave_mode && green_led && !autorun_mode)
    else $error("held halls did not force slave mode");

  a_no_program: assert property (
    st_read && nvm_rd_valid && !program_valid_in
      |=> slave_mode && !autorun_mode ##1 !program_run)
    else $error("slave mode missing without program");

  a_rot_zero: assert property (
    s_capture and ($past(s_rot) == ROT_ZERO)
      |-> lss_unconf == $past(s_proto) && serial_axis_id == ID_UNCONF)
    else $error("rotary zero handled wrongly");

  a_rot_id: assert property (
    s_capture and ($past(s_rot) != ROT_ZERO)
      |-> axis_id == {4'h0, $past(s_rot)} && !lss_unconf)
    else $error("axis id differs from rotary");

  a_serial_id: assert property (
    lss_unconf |-> serial_axis_id == ID_UNCONF)
    else $error("serial id not 255 while unconfigured");

  a_can_gate: assert property (
    lss_unconf |-> !can_comm_en)
    else $error("CAN enabled while unconfigured");

  a_lss_assign: assert property (
    lss_take && cfg_done |=> axis_id == $past(pwdata[7:0])
      && !lss_unconf ##1 can_comm_en)
    else $error("LSS assignment not accepted");

  a_canopen_max: assert property (
    canopen_mode && cfg_done |-> axis_id <= ID_CANOPEN_MAX)
    else $error("CANopen id above 127");

  a_cfg_hold: assert property (
    cfg_done |=> $stable(canopen_mode) && $stable(autorun_mode)
      && $stable(slave_mode))
    else $error("power-on result changed after start-up");
endmodule
`default_nettype wire

// ### dv/dba_nvm_model.sv
// Nonvolatile memory model answering the loader's flag word requests
`default_nettype none
module dba_nvm_model
  import dba_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic nvm_rd_req,
  input wire logic [15:0] nvm_addr,
  output logic nvm_rd_valid,
  output logic [15:0] nvm_rd_data,
  input wire logic nvm_wr_req,
  input wire logic [15:0] nvm_wr_data,
  output logic nvm_wr_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Storage survives reset, as real nonvolatile memory does
  logic [15:0] mem_word = 16'h0000;
  int rd_cnt;
  int wr_cnt;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_cnt <= 0;
      wr_cnt <= 0;
      nvm_rd_valid <= 1'b0;
      nvm_wr_ack <= 1'b0;
      nvm_rd_data <= 16'hA5A5;
    end else begin
      nvm_rd_valid <= 1'b0;
      nvm_wr_ack <= 1'b0;
      // Released bus: never leave the last word standing
      nvm_rd_data <= ~nvm_rd_data;
      if (rd_cnt > 1) begin
        rd_cnt <= rd_cnt - 1;
      end else if (rd_cnt == 1) begin
        rd_cnt <= 0;
        nvm_rd_valid <= 1'b1;
        nvm_rd_data <= (nvm_addr == NVM_AUTORUN_ADDR) ? mem_word : 16'hFFFF;
      end else if (nvm_rd_req) begin
        rd_cnt <= slow ? 6 : 1;
      end
      if (wr_cnt > 1) begin
        wr_cnt <= wr_cnt - 1;
      end else if (wr_cnt == 1) begin
        wr_cnt <= 0;
        nvm_wr_ack <= 1'b1;
        if (nvm_addr == NVM_AUTORUN_ADDR) begin
          mem_word <= nvm_wr_data;
        end
      end else if (nvm_wr_req && !nvm_wr_ack) begin
        wr_cnt <= slow ? 4 : 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/drive_boot_mode_and_axis_id_select_bench.sv
// Self-checking bench for the boot mode and axis id loader
`default_nettype none
module drive_boot_mode_and_axis_id_select_bench
  import dba_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, reset_n = 0, protocol_switch = 0, motor_supply_ok = 0;
  logic [3:0] rot = 4'h0;
  logic [2:0] hall_in = 3'h7;
  logic prog_ok = 0, slow = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, err_seen, done_seen = 0;
  logic rd_req, wr_req, rd_valid, wr_ack, canopen, native, autorun, slave;
  logic run, led, done, lss, can_en;
  logic [15:0] addr, rd_data, wr_data;
  logic [7:0] axis_id, serial_id;
  int fails = 0, cmp_count = 0, seed = 32'h0fb3;
  logic [31:0] exp_q[$];
  string tag_q[$];
  always #20 sys_clk = ~sys_clk;
  dba_boot_cfg #(.HALL_HOLD_CYCLES(20)) DUT (.sys_clk(sys_clk),
    .reset_n(reset_n), .protocol_switch(protocol_switch),
    .axis_id_rotary_switch(rot), .hall_in(hall_in),
    .motor_supply_ok(motor_supply_ok), .program_valid_in(prog_ok),
    .nvm_rd_req(rd_req), .nvm_addr(addr), .nvm_rd_valid(rd_valid),
    .nvm_rd_data(rd_data), .nvm_wr_req(wr_req), .nvm_wr_data(wr_data),
    .nvm_wr_ack(wr_ack), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .canopen_mode(canopen),
    .native_command_protocol_mode(native), .autorun_mode(autorun),
    .slave_mode(slave), .program_run(run), .green_led(led),
    .cfg_done(done), .lss_unconf(lss), .can_comm_en(can_en),
    .axis_id(axis_id), .serial_axis_id(serial_id));
  dba_nvm_model NVM (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow),
    .nvm_rd_req(rd_req), .nvm_addr(addr), .nvm_rd_valid(rd_valid),
    .nvm_rd_data(rd_data), .nvm_wr_req(wr_req), .nvm_wr_data(wr_data),
    .nvm_wr_ack(wr_ack));
  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic take(input logic [31:0] seen);
    if (exp_q.size() == 0) begin
      fails++;
      $display("ERROR unexpected result %h", seen);
    end else begin
      check(tag_q.pop_front(), seen, exp_q.pop_front());
    end
  endtask
  // Settled values are sampled half a period after the edge
  always @(negedge sys_clk) begin
    if (!reset_n) begin
      done_seen = 0;
    end else if (done === 1'b1 && !done_seen) begin
      done_seen = 1;
      take({10'h0, canopen, native, autorun, slave, led, lss, axis_id,
        serial_id});
    end else if (pready === 1'b1 && !pwrite) begin
      take(prdata);
    end
  end
  function automatic logic [31:0] boot_exp(input logic c, input logic [3:0] r,
      input logic off, pv, hlow);
    logic ar, gr;
    logic [7:0] ax, se;
    ar = !c && pv && !off && !hlow;
    gr = !c && pv && !off && hlow;
    se = (r == ROT_ZERO) ? ID_UNCONF : {4'h0, r};
    ax = (r != ROT_ZERO) ? se : (c ? ID_NONE : ID_UNCONF);
    return {10'h0, c, !c, ar, !ar, gr, c && (r == ROT_ZERO), ax, se};
  endfunction
  // ==========================================================
  // Stimulus
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input string what, input logic [31:0] e);
    int n;
    if (!w) begin
      exp_q.push_back(e);
      tag_q.push_back(what);
    end
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic boot(input logic c, input logic [3:0] r, input logic off,
      pv, input logic [2:0] h, input logic m);
    int n;
    @(posedge sys_clk);
    reset_n <= 0;
    protocol_switch <= c;
    rot <= r;
    prog_ok <= pv;
    hall_in <= h;
    motor_supply_ok <= m;
    slow <= $random(seed) & 1;
    NVM.mem_word = off ? NVM_AUTORUN_OFF : 16'h0000;
    exp_q.push_back(boot_exp(c, r, off, pv, h == HALL_ALL_LOW));
    tag_q.push_back("boot modes");
    repeat (4) @(posedge sys_clk);
    reset_n <= 1;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) fails++;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
  initial begin
    // Native autorun waits for the motor supply before running
    boot(0, 4'h0, 0, 1, 3'h5, 0);
    apb(0, REG_STATUS, 0, "status idle", 32'h0000_0122);
    motor_supply_ok <= 1;
    repeat (10) @(posedge sys_clk);
    apb(0, REG_STATUS, 0, "status run", 32'h0000_0132);
    rot <= 4'h5;
    hall_in <= 3'h0;
    repeat (12) @(posedge sys_clk);
    apb(0, REG_AXIS, 0, "axis held", 32'h0000_FFFF);
    apb(1, REG_AUTORUN, 32'h1, "", 0);
    repeat (20) @(posedge sys_clk);
    check("nvm flag", {16'h0, NVM.mem_word}, 32'h0001);
    check("slave kept", {31'h0, slave}, 32'h0);
    apb(0, 8'h10, 0, "unmapped", 32'h0);
    check("unmapped err", {31'h0, err_seen}, 32'h1);
    $display("Test autorun done");
    boot(0, 4'h3, 1, 1, 3'h5, 1);
    boot(0, 4'h7, 0, 1, 3'h0, 1);
    boot(0, 4'h9, 0, 0, 3'h0, 1);
    $display("Test boot modes done");
    boot(1, 4'h0, 0, 1, 3'h5, 1);
    check("can off", {31'h0, can_en}, 32'h0);
    apb(0, REG_LSS, 0, "lss id", 32'h0);
    apb(1, REG_LSS, 32'h0000_01C8, "", 0);
    apb(0, REG_LSS, 0, "lss high id", 32'h0);
    apb(1, REG_LSS, 32'h0000_012A, "", 0);
    repeat (3) @(posedge sys_clk);
    check("can on", {31'h0, can_en}, 32'h1);
    check("lss state", {31'h0, lss}, 32'h0);
    apb(0, REG_LSS, 0, "lss new id", 32'h0000_002A);
    $display("Test lss done");
    for (int r = 1; r < 16; r++) begin
      boot(r[0], r[3:0], 0, 1, 3'(($random(seed) & 3) + 1), 1);
      apb(0, REG_AXIS, 0, "axis reg", {16'h0, {2{4'h0, r[3:0]}}});
    end
    $display("Test rotary done");
    print_verdict();
  end
endmodule
`default_nettype wire
